// [verilog/acc_core.sv]
// Conversion control, status, result and threshold registers of the ADC block
//
// How it works
// - Writing 0x02 to control register sets the single-conversion request bit D1.
// - Parallel port: request taken on the write strobe falling edge.
// - Serial port: request taken on rising edge of either select line.
// - Pending request is captured on next rising conversion clock edge.
// - A control register read before that edge cancels the pending request.
// - Bits D3..D1 read live sequencer state, not stored bits.
// - Request bit D1 clears at the 25th conversion clock edge.
// - Done D3 and busy D2 toggle at the 38th conversion clock edge.
// - Status changing mid serial read gives a parity error; host re-reads.
// - Parallel read data and parity follow status changes transparently.
// - Writing any value with bit 4 set (0x10, 0x30, ..., 0xF0) sets continuous-enable bit D4, repeating conversions.
// - Continuous period is 40 + 55*(2^N - 1) conversion clock cycles.
// - Continuous results stay until the next conversion replaces them.
// - Result high register holds bits 11..4, low register bits 3..0.
// - Upper four bits of the low result register read zero.
// - Both result registers clear on power-on or reset input.
// - Threshold register holds host-written 8-bit comparator threshold code.
// - Threshold register returns to 0x00 after any reset.
// - Results keep old value until the 39th conversion clock edge.
// - Sequencer resets only at power-up, not by reset input or soft reset.
// - Clearing continuous-enable stops only after current conversion ends.
module acc_core
   import acc_pkg::*;
#(
   parameter bit       ODD_PARITY = 1'b1
) (
   input  wire logic                        core_clk,
   input  wire logic                        rst_b,
   input  wire logic                        por_b,
   input  wire logic                        soft_reset,
   input  wire logic                        conv_clk_pin,
   input  wire logic                        par_we_b,
   input  wire logic                        par_oe_b,
   input  wire logic [acc_pkg::ADDR_W-1:0]  par_addr,
   input  wire logic [acc_pkg::DATA_W-1:0]  par_wdata,
   output logic      [acc_pkg::DATA_W-1:0]  par_rdata,
   output logic                             par_parity,
   output logic                             par_data_oe,
   input  wire logic                        host_a_select,
   input  wire logic                        host_b_select,
   input  wire logic                        spi_write,
   input  wire logic [acc_pkg::ADDR_W-1:0]  spi_addr,
   input  wire logic [acc_pkg::DATA_W-1:0]  spi_wdata,
   output logic      [acc_pkg::DATA_W-1:0]  spi_rdata,
   output logic                             spi_parity,
   input  wire logic [acc_pkg::RES_W-1:0]   sar_result,
   output logic      [acc_pkg::DATA_W-1:0]  threshold_code_bits,
   output logic                             conv_busy
);
   import acc_pkg::*;

   localparam int SYNC_W = 6 + 2 * ADDR_W + 2 * DATA_W;

   // ****************************************************************
   // Functions
   // ****************************************************************
   // Continuous conversion period for a rate code
   function automatic logic [CNT_W-1:0] conv_period(input logic [RATE_W-1:0] n);
      logic [CNT_W-1:0] steps;
      steps = (CNT_W'(1) << n) - CNT_W'(1);
      conv_period = PERIOD_BASE + CNT_W'(PERIOD_STEP * steps);
   endfunction

   // Parity bit over one byte
   function automatic logic byte_parity(input logic [DATA_W-1:0] d);
      byte_parity = (^d) ^ ODD_PARITY;
   endfunction

   // ****************************************************************
   // Synchronisers for all host pins and the conversion clock
   // ****************************************************************
   logic [SYNC_W-1:0] pins_sync;
   logic              we_b_s, oe_b_s, sel_a_s, sel_b_s, spi_wr_s, cclk_s;
   logic [ADDR_W-1:0] par_addr_s, spi_addr_s;
   logic [DATA_W-1:0] par_wdata_s, spi_wdata_s;

   acc_sync #(
      .W    (SYNC_W),
      .INIT (1'b1)
   ) u_sync (
      .core_clk (core_clk),
      .rst_b    (por_b),
      .async_in ({par_we_b, par_oe_b, host_a_select, host_b_select, spi_write,
                  conv_clk_pin, par_addr, spi_addr, par_wdata, spi_wdata}),
      .sync_out (pins_sync)
   );

   assign {we_b_s, oe_b_s, sel_a_s, sel_b_s, spi_wr_s, cclk_s,
           par_addr_s, spi_addr_s, par_wdata_s, spi_wdata_s} = pins_sync;

   // Previous synchronised levels for edge detection
   logic we_b_reg, oe_b_reg, sel_a_reg, sel_b_reg, cclk_reg;

   always_ff @(posedge core_clk or negedge por_b) begin
      if (!por_b) begin
         we_b_reg  <= 1'b1;
         oe_b_reg  <= 1'b1;
         sel_a_reg <= 1'b1;
         sel_b_reg <= 1'b1;
         cclk_reg  <= 1'b1;
      end else begin
         we_b_reg  <= we_b_s;
         oe_b_reg  <= oe_b_s;
         sel_a_reg <= sel_a_s;
         sel_b_reg <= sel_b_s;
         cclk_reg  <= cclk_s;
      end
   end

   // ****************************************************************
   // Host access events
   // ****************************************************************
   // Select rise ends a serial frame; select fall starts it
   wire par_wr_ev  = we_b_reg & ~we_b_s;
   wire par_rd_ev  = oe_b_reg & ~oe_b_s;
   wire sel_rise   = (~sel_a_reg & sel_a_s) | (~sel_b_reg & sel_b_s);
   wire sel_fall   = (sel_a_reg & ~sel_a_s) | (sel_b_reg & ~sel_b_s);
   wire spi_wr_ev  = sel_rise & spi_wr_s;
   wire spi_rd_ev  = sel_fall & ~spi_wr_s;
   wire conv_edge  = ~cclk_reg & cclk_s;

   // Parallel write wins if both ports write in one cycle
   wire              wr_ev   = par_wr_ev | spi_wr_ev;
   wire [ADDR_W-1:0] wr_addr = par_wr_ev ? par_addr_s : spi_addr_s;
   wire [DATA_W-1:0] wr_data = par_wr_ev ? par_wdata_s : spi_wdata_s;

   wire ctrl_wr    = wr_ev & (wr_addr == ADDR_CTRL);
   wire thresh_wr  = wr_ev & (wr_addr == ADDR_THRESH);
   wire ctrl_rd    = (par_rd_ev & (par_addr_s == ADDR_CTRL)) |
                     (spi_rd_ev & (spi_addr_s == ADDR_CTRL));
   wire start_cmd  = wr_data[BIT_SINGLE];
   wire auto_cmd   = wr_data[BIT_AUTO];

   // ****************************************************************
   // Sequencer state, reset only at power-up
   // ****************************************************************
   acc_state_t       state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic             pend_single_reg, pend_auto_reg;
   logic             auto_reg, single_run_reg, done_reg, load_reg;
   logic [RATE_W-1:0] rate_reg;

   wire [CNT_W-1:0] period   = conv_period(rate_reg);
   wire             pend_any = pend_single_reg | pend_auto_reg;
   wire             can_start = (state_reg == ACC_IDLE) |
                                ((state_reg == ACC_HOLD) & (cnt_reg >= EDGE_RESULT));
   wire             auto_restart = (state_reg == ACC_HOLD) & auto_reg & (cnt_reg == period);
   wire             start_now = conv_edge & ((can_start & pend_any) | auto_restart);

   // Next state of the conversion sequencer
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      if (start_now) begin
         state_next = ACC_CONV;
         cnt_next   = EDGE_FIRST;
      end else if (conv_edge) begin
         case (state_reg)
            ACC_IDLE: begin
               cnt_next = cnt_reg;
            end
            ACC_CONV: begin
               cnt_next = cnt_reg + CNT_W'(1);
               if (cnt_next == EDGE_READY) begin
                  state_next = ACC_HOLD;
               end
            end
            ACC_HOLD: begin
               cnt_next = cnt_reg + CNT_W'(1);
               if (!auto_reg && cnt_reg >= EDGE_RESULT) begin
                  state_next = ACC_IDLE;
               end
            end
            default: begin
               state_next = ACC_IDLE;
            end
         endcase
      end
   end

   // Sequencer registers; the reset input deliberately does not reach them
   always_ff @(posedge core_clk or negedge por_b) begin
      if (!por_b) begin
         state_reg <= ACC_IDLE;
         cnt_reg   <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
      end
   end

   // Pending commands: a new write wins over a same-cycle cancelling read
   always_ff @(posedge core_clk or negedge por_b) begin
      if (!por_b) begin
         pend_single_reg <= 1'b0;
         pend_auto_reg   <= 1'b0;
      end else if (ctrl_wr) begin
         pend_single_reg <= start_cmd;
         pend_auto_reg   <= auto_cmd;
      end else if (ctrl_rd) begin
         pend_single_reg <= 1'b0;
         pend_auto_reg   <= 1'b0;
      end else if (conv_edge && can_start) begin
         pend_single_reg <= 1'b0;
         pend_auto_reg   <= 1'b0;
      end
   end

   // Mode bits: stop takes effect at once but never aborts a conversion
   always_ff @(posedge core_clk or negedge por_b) begin
      if (!por_b) begin
         auto_reg <= 1'b0;
         rate_reg <= RATE_RST;
      end else if (ctrl_wr) begin
         rate_reg <= wr_data[RATE_LSB +: RATE_W];
         if (!auto_cmd) begin
            auto_reg <= 1'b0;
         end
      end else if (conv_edge && can_start && pend_auto_reg) begin
         auto_reg <= 1'b1;
      end
   end

   // Done flag and result load strobe
   always_ff @(posedge core_clk or negedge por_b) begin
      if (!por_b) begin
         done_reg       <= 1'b0;
         single_run_reg <= 1'b0;
         load_reg       <= 1'b0;
      end else begin
         load_reg <= conv_edge & (state_reg == ACC_HOLD) & (cnt_next == EDGE_RESULT);
         if (start_now) begin
            done_reg       <= 1'b0;
            single_run_reg <= ~auto_restart & pend_single_reg;
         end else if (conv_edge && state_next == ACC_HOLD && state_reg == ACC_CONV) begin
            done_reg <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // Result and threshold registers, cleared by any reset
   // ****************************************************************
   logic [DATA_W-1:0] res_high_reg, res_low_reg, thresh_reg;
   wire               any_rst_b = rst_b & por_b;

   always_ff @(posedge core_clk or negedge any_rst_b) begin
      if (!any_rst_b) begin
         res_high_reg <= RES_HIGH_RST;
         res_low_reg  <= RES_LOW_RST;
         thresh_reg   <= THRESH_RST;
      end else if (soft_reset) begin
         res_high_reg <= RES_HIGH_RST;
         res_low_reg  <= RES_LOW_RST;
         thresh_reg   <= THRESH_RST;
      end else begin
         if (load_reg) begin
            // Held until the 39th edge of the next conversion
            res_high_reg <= sar_result[RES_W-1:RES_SPLIT];
            res_low_reg  <= {4'h0, sar_result[RES_SPLIT-1:0]};
         end
         if (thresh_wr) begin
            thresh_reg <= wr_data;
         end
      end
   end

   // ****************************************************************
   // Live status and read data
   // ****************************************************************
   // Status bits come straight from sequencer state, never latched
   wire busy_now   = (state_reg == ACC_CONV);
   wire single_now = pend_single_reg |
                     (busy_now & single_run_reg & (cnt_reg < EDGE_HOLD));
   // Auto bit shows a pending start too, as the request bit does
   wire [DATA_W-1:0] ctrl_view = {rate_reg, auto_reg | pend_auto_reg, done_reg, busy_now,
                                  single_now, 1'b0};

   function automatic logic [DATA_W-1:0] read_mux(input logic [ADDR_W-1:0] a,
                                                  input logic [DATA_W-1:0] c,
                                                  input logic [DATA_W-1:0] h,
                                                  input logic [DATA_W-1:0] l,
                                                  input logic [DATA_W-1:0] t);
      case (a)
         ADDR_CTRL:     read_mux = c;
         ADDR_RES_HIGH: read_mux = h;
         ADDR_RES_LOW:  read_mux = l;
         ADDR_THRESH:   read_mux = t;
         default:       read_mux = 8'h00;
      endcase
   endfunction

   // Parallel read follows status during the strobe, no snapshot
   assign par_rdata   = read_mux(par_addr_s, ctrl_view, res_high_reg, res_low_reg,
                                 thresh_reg);
   assign par_parity  = byte_parity(par_rdata);
   assign par_data_oe = ~oe_b_s;

   // Serial read is live too; a change mid-frame shows as bad parity
   assign spi_rdata   = read_mux(spi_addr_s, ctrl_view, res_high_reg, res_low_reg,
                                 thresh_reg);
   assign spi_parity  = byte_parity(spi_rdata);

   assign threshold_code_bits = thresh_reg;
   assign conv_busy           = busy_now;

endmodule

// [verilog/acc_pkg.sv]
// Package with register map, field positions, reset values and sequencer timing
package acc_pkg;

   // ****************************************************************
   // Register map and widths
   // ****************************************************************
   localparam int          ADDR_W         = 5;
   localparam int          DATA_W         = 8;
   localparam int          RES_W          = 12;
   localparam int          CNT_W          = 13;
   localparam logic [4:0]  ADDR_CTRL      = 5'h08;
   localparam logic [4:0]  ADDR_RES_HIGH  = 5'h09;
   localparam logic [4:0]  ADDR_RES_LOW   = 5'h0a;
   localparam logic [4:0]  ADDR_THRESH    = 5'h0b;

   // ****************************************************************
   // Control register fields and result split position
   // ****************************************************************
   localparam int          BIT_SINGLE     = 1;
   localparam int          BIT_BUSY       = 2;
   localparam int          BIT_DONE       = 3;
   localparam int          BIT_AUTO       = 4;
   localparam int          RATE_LSB       = 5;
   localparam int          RATE_W         = 3;
   localparam int          RES_SPLIT      = 4;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [7:0]  RES_HIGH_RST   = 8'h00;
   localparam logic [7:0]  RES_LOW_RST    = 8'h00;
   localparam logic [7:0]  THRESH_RST     = 8'h00;
   localparam logic [2:0]  RATE_RST       = 3'h0;

   // ****************************************************************
   // Sequencer timing, in rising conversion clock edges
   // ****************************************************************
   localparam logic [12:0] EDGE_FIRST     = 13'h0001;
   localparam logic [12:0] EDGE_HOLD      = 13'h0019;  // 25th: request bit drops
   localparam logic [12:0] EDGE_READY     = 13'h0026;  // 38th: busy/done toggle
   localparam logic [12:0] EDGE_RESULT    = 13'h0027;  // 39th: result visible
   localparam logic [12:0] PERIOD_BASE    = 13'h0028;  // 40
   localparam logic [12:0] PERIOD_STEP    = 13'h0037;  // 55

   // Sequencer states
   typedef enum logic [2:0] {
      ACC_IDLE = 3'b001,
      ACC_CONV = 3'b010,
      ACC_HOLD = 3'b100
   } acc_state_t;

endpackage

// [verilog/acc_sync.sv]
// Two-flop synchroniser for a vector of asynchronous inputs
module acc_sync #(
   parameter int       W    = 1,
   parameter logic     INIT = 1'b0
) (
   input  wire logic         core_clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] async_in,
   output logic [W-1:0]      sync_out
);

   logic [W-1:0] meta_reg;

   // ****************************************************************
   // First flop feeds only the second
   // ****************************************************************
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_reg <= {W{INIT}};
         sync_out <= {W{INIT}};
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule

// [testbench/acc_core_monitor.sv]
// Port checker for the conversion control block, attached by bind
module acc_core_monitor
   import acc_pkg::*;
#(
   parameter bit ODD_PARITY = 1'b1
) (
   input wire logic                       core_clk,
   input wire logic                       rst_b,
   input wire logic                       por_b,
   input wire logic                       par_oe_b,
   input wire logic [acc_pkg::ADDR_W-1:0] par_addr,
   input wire logic [acc_pkg::DATA_W-1:0] par_rdata,
   input wire logic                       par_parity,
   input wire logic                       par_data_oe,
   input wire logic [acc_pkg::ADDR_W-1:0] spi_addr,
   input wire logic [acc_pkg::DATA_W-1:0] spi_rdata,
   input wire logic                       spi_parity,
   input wire logic [acc_pkg::DATA_W-1:0] threshold_code_bits,
   input wire logic                       conv_busy
);
   timeunit 1ns;
   timeprecision 1ns;
   // 37 conversion periods of at least 6 core cycles each
   localparam int BUSY_MIN = 222;
   logic [15:0] busy_len;

   // Busy span counter; an aborted conversion would show a short span
   always_ff @(posedge core_clk or negedge por_b) begin
      if (!por_b) busy_len <= 16'h0000;
      else if (conv_busy) busy_len <= busy_len + 16'h0001;
      else busy_len <= 16'h0000;
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!por_b);
   // Address held long enough to pass the synchronisers
   sequence s_par_at(logic [4:0] a);
      (par_addr == a)[*5];
   endsequence
   sequence s_spi_at(logic [4:0] a);
      (spi_addr == a)[*5];
   endsequence

   a_par_parity: assert property (par_parity == (^par_rdata ^ ODD_PARITY))
      else $error("parallel parity does not match data");
   a_spi_parity: assert property (spi_parity == (^spi_rdata ^ ODD_PARITY))
      else $error("serial parity does not match data");
   a_low_nibble: assert property (s_spi_at(ADDR_RES_LOW) |-> spi_rdata[7:4] == 4'h0)
      else $error("low result upper bits not zero");
   a_ctrl_busy: assert property (s_par_at(ADDR_CTRL) |-> par_rdata[BIT_BUSY] == conv_busy)
      else $error("control busy bit differs from live busy");
   a_thresh_view: assert property (s_par_at(ADDR_THRESH) |-> par_rdata == threshold_code_bits)
      else $error("threshold read differs from threshold output");
   a_thresh_clear: assert property (!rst_b |-> threshold_code_bits == THRESH_RST)
      else $error("threshold not cleared under reset");
   a_busy_span: assert property ($fell(conv_busy) |-> busy_len >= BUSY_MIN)
      else $error("busy span too short");
   a_oe_drive: assert property ((!par_oe_b)[*6] |-> par_data_oe)
      else $error("data pins not driven during read");
   a_oe_release: assert property (par_oe_b[*6] |-> !par_data_oe)
      else $error("data pins driven outside read");
endmodule

bind acc_core acc_core_monitor #(.ODD_PARITY(ODD_PARITY)) i_mon (
   .core_clk(core_clk), .rst_b(rst_b), .por_b(por_b), .par_oe_b(par_oe_b),
   .par_addr(par_addr), .par_rdata(par_rdata), .par_parity(par_parity),
   .par_data_oe(par_data_oe), .spi_addr(spi_addr), .spi_rdata(spi_rdata),
   .spi_parity(spi_parity), .threshold_code_bits(threshold_code_bits),
   .conv_busy(conv_busy));

// [testbench/acc_conv_src.sv]
// Conversion clock source model; halted low outside runs, counts rising edges
module acc_conv_src #(
   parameter int HALF = 4
) (
   input wire logic core_clk,
   input wire logic run,
   output logic     conv_clk_pin,
   output int       edges
);
   timeunit 1ns;
   timeprecision 1ns;
   int ph = 0;

   // Each level lasts HALF core cycles, above the 3-cycle sampling floor
   always @(negedge core_clk) begin
      if (!run) begin
         ph <= 0;
         conv_clk_pin <= 1'b0;
         edges <= 0;
      end else if (ph == HALF - 1) begin
         ph <= 0;
         conv_clk_pin <= !conv_clk_pin;
         if (!conv_clk_pin) edges <= edges + 1;
      end else begin
         ph <= ph + 1;
      end
   end
endmodule

// [testbench/acc_core_bench.sv]
// Self-checking bench for the conversion control block
module acc_core_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import acc_pkg::*;
   logic        core_clk, rst_b, por_b, soft_reset, run;
   logic        par_we_b, par_oe_b, host_a_select, host_b_select, spi_write;
   logic        par_parity, par_data_oe, spi_parity, conv_busy, conv_clk;
   logic [4:0]  par_addr, spi_addr;
   logic [7:0]  par_wdata, spi_wdata, par_rdata, spi_rdata, thr;
   logic [11:0] sar;
   int          edges;
   int          error_cnt = 0;
   int          num_checks = 0;

   acc_core i_dut (
      .core_clk(core_clk), .rst_b(rst_b), .por_b(por_b), .soft_reset(soft_reset),
      .conv_clk_pin(conv_clk), .par_we_b(par_we_b), .par_oe_b(par_oe_b),
      .par_addr(par_addr), .par_wdata(par_wdata), .par_rdata(par_rdata),
      .par_parity(par_parity), .par_data_oe(par_data_oe),
      .host_a_select(host_a_select), .host_b_select(host_b_select),
      .spi_write(spi_write), .spi_addr(spi_addr), .spi_wdata(spi_wdata),
      .spi_rdata(spi_rdata), .spi_parity(spi_parity), .sar_result(sar),
      .threshold_code_bits(thr), .conv_busy(conv_busy));
   acc_conv_src i_src (.core_clk(core_clk), .run(run), .conv_clk_pin(conv_clk), .edges(edges));

   // ****************************************************************
   // Clock, checks and bus tasks
   // ****************************************************************
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   // Address and data settle 3 cycles before the strobe edge
   task automatic pwr(input logic [4:0] a, input logic [7:0] d);
      par_addr = a;
      par_wdata = d;
      cyc(3);
      par_we_b = 1'b0;
      cyc(4);
      par_we_b = 1'b1;
      cyc(4);
   endtask
   task automatic rchk(input string nm, input logic [4:0] a, input logic [7:0] e);
      par_addr = a;
      cyc(1);
      par_oe_b = 1'b0;
      cyc(4);
      chk(nm, par_rdata, e);
      par_oe_b = 1'b1;
      cyc(4);
   endtask
   task automatic swr(input logic [4:0] a, input logic [7:0] d, input bit b);
      spi_write = 1'b1;
      spi_addr = a;
      spi_wdata = d;
      cyc(1);
      if (b) host_b_select = 1'b0;
      else host_a_select = 1'b0;
      cyc(4);
      host_a_select = 1'b1;
      host_b_select = 1'b1;
      cyc(4);
   endtask
   // Waits past the synchronisers after rising edge n of the conversion clock
   task automatic step(input int n);
      while (edges < n) @(negedge core_clk);
      cyc(5);
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset();
      rchk("res_high", ADDR_RES_HIGH, RES_HIGH_RST);
      rchk("res_low", ADDR_RES_LOW, RES_LOW_RST);
      rchk("thresh", ADDR_THRESH, THRESH_RST);
      rchk("unmapped", 5'h1f, 8'h00);
   endtask
   task automatic t_thresh();
      pwr(ADDR_THRESH, 8'ha5);
      rchk("thresh", ADDR_THRESH, 8'ha5);
      chk("thr_pins", thr, 8'ha5);
      swr(ADDR_THRESH, 8'h3c, 1'b0);
      rchk("thresh_spi", ADDR_THRESH, 8'h3c);
      pwr(ADDR_RES_HIGH, 8'hff);
      rchk("res_ro", ADDR_RES_HIGH, 8'h00);
      rst_b = 1'b0;
      cyc(2);
      rst_b = 1'b1;
      cyc(3);
      rchk("thresh_rst", ADDR_THRESH, THRESH_RST);
   endtask
   // Reading control before the first conversion edge drops the start
   task automatic t_cancel();
      pwr(ADDR_CTRL, 8'h02);
      chk("ctrl_read", par_rdata, 8'h02);
      rchk("ctrl_cancel", ADDR_CTRL, 8'h00);
      run = 1'b1;
      step(3);
      chk("ctrl", par_rdata, 8'h00);
      chk("busy", {7'h0, conv_busy}, 8'h00);
      run = 1'b0;
   endtask
   task automatic t_single_par();
      sar = 12'habc;
      spi_addr = ADDR_RES_HIGH;
      pwr(ADDR_CTRL, 8'h02);
      chk("ctrl_w", par_rdata, 8'h02);
      run = 1'b1;
      step(1);
      chk("ctrl_e1", par_rdata, 8'h06);
      par_oe_b = 1'b0;
      step(24);
      chk("ctrl_e24", par_rdata, 8'h06);
      step(25);
      chk("ctrl_e25", par_rdata, 8'h04);
      step(38);
      chk("ctrl_e38", par_rdata, 8'h08);
      chk("busy_e38", {7'h0, conv_busy}, 8'h00);
      chk("oe_e38", {7'h0, par_data_oe}, 8'h01);
      chk("old_res", spi_rdata, 8'h00);
      step(39);
      chk("res_high", spi_rdata, 8'hab);
      spi_addr = ADDR_RES_LOW;
      cyc(4);
      chk("res_low", spi_rdata, 8'h0c);
      par_oe_b = 1'b1;
      run = 1'b0;
   endtask
   // Serial start, then both resets in mid-conversion
   task automatic t_single_ser();
      sar = 12'h5a3;
      swr(ADDR_CTRL, 8'h02, 1'b1);
      spi_addr = ADDR_RES_HIGH;
      cyc(4);
      chk("ctrl_s", par_rdata, 8'h0a);
      run = 1'b1;
      step(10);
      rst_b = 1'b0;
      cyc(2);
      rst_b = 1'b1;
      soft_reset = 1'b1;
      cyc(1);
      soft_reset = 1'b0;
      step(12);
      chk("busy_rst", {7'h0, conv_busy}, 8'h01);
      chk("res_rst", spi_rdata, 8'h00);
      step(38);
      chk("ctrl_done", par_rdata, 8'h08);
      step(39);
      chk("res_s", spi_rdata, 8'h5a);
      run = 1'b0;
   endtask
   // Rate 1 gives a period of 40 + 55 = 95 edges
   task automatic t_auto();
      sar = 12'h123;
      pwr(ADDR_CTRL, 8'h30);
      chk("ctrl_auto", par_rdata, 8'h38);
      run = 1'b1;
      step(1);
      chk("busy1", {7'h0, conv_busy}, 8'h01);
      step(39);
      chk("res1", spi_rdata, 8'h12);
      sar = 12'h9f0;
      step(95);
      chk("gap", {7'h0, conv_busy}, 8'h00);
      step(96);
      chk("busy2", {7'h0, conv_busy}, 8'h01);
      pwr(ADDR_CTRL, 8'h00);
      step(132);
      chk("busy_stop", {7'h0, conv_busy}, 8'h01);
      step(133);
      chk("res_keep", spi_rdata, 8'h12);
      step(134);
      chk("res2", spi_rdata, 8'h9f);
      step(192);
      chk("stopped", {7'h0, conv_busy}, 8'h00);
      run = 1'b0;
   endtask

   // ****************************************************************
   // Main sequence and watchdog
   // ****************************************************************
   initial begin
      repeat (20000) @(posedge core_clk);
      error_cnt++;
      end_of_test();
   end
   initial begin
      {rst_b, por_b, soft_reset, run, par_we_b, par_oe_b} = 6'b000011;
      {host_a_select, host_b_select, spi_write} = 3'b110;
      {par_addr, spi_addr, par_wdata, spi_wdata, sar} = 38'h0;
      cyc(16);
      por_b = 1'b1;
      rst_b = 1'b1;
      cyc(4);
      t_reset();
      t_thresh();
      t_cancel();
      t_single_par();
      t_single_ser();
      t_auto();
      end_of_test();
   end
endmodule
